//--- testbench/pad_mux_control_tb_top.sv
`timescale 1ns/1ns
`include "padmux_params.svh"

module pad_mux_control_tb_top;
    localparam int          N = `PADMUX_NUM_PADS;
    localparam logic [31:0] B = `PADMUX_PAD0_ADDR;
    localparam logic [31:0] L = `PADMUX_LOCK_ADDR;
    logic           ref_clk_i = 0, reset_i = 1, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0, lock_active_o;
    logic [31:0]    reg_addr_i = '0, reg_wdata_i = '0, reg_rdata_o, e_rd;
    logic [N*4-1:0] func_out_i, func_oe_i;
    logic [N-1:0]   fabric_oe_i, pad_in_i, pad_out_o, pad_oe_o, pad_rx_o, pad_slew_fast_o, pad_schmitt_enable_o;
    logic [N-1:0]   e_out, e_oe, e_rx, e_slew, e_smt;
    logic [N*2-1:0] pad_pull_o, pad_drive_o, e_pull, e_drv;
    logic [12:0]    ctrl_m [N];
    logic           lock_m, e_lock, armed = 0;
    integer         seed = 32'h319c;
    int             p, bad_count = 0, n_compared = 0;

    padmux_top #(.NUM_PADS(N)) dut_u (.ref_clk_i, .reset_i, .clk_en_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .func_out_i, .func_oe_i, .fabric_oe_i, .pad_in_i, .pad_out_o, .pad_oe_o,
        .pad_rx_o, .pad_pull_o, .pad_drive_o, .pad_slew_fast_o, .pad_schmitt_enable_o, .lock_active_o);
    padmux_pad_world #(.NUM_PADS(N)) world_u (.ref_clk_i, .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pad_pull_i(pad_pull_o), .func_out_o(func_out_i), .func_oe_o(func_oe_i), .fabric_oe_o(fabric_oe_i),
        .pad_in_o(pad_in_i));

    always #5 ref_clk_i = ~ref_clk_i;

    function automatic int pad_of(logic [31:0] a);
        if (a[1:0] != 2'h0 || a < B || a >= B + 4 * N)
            return -1;
        return int'((a - B) >> 2);
    endfunction

    // The model reads inputs before this edge's updates land, as the design's flops do.
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            foreach (ctrl_m[g]) ctrl_m[g] = `PADMUX_CTRL_RESET;
            lock_m = 1'b1;
            e_lock = 1'b1;
            armed = 1'b1;
            e_rd = '0;
            {e_out, e_oe, e_rx, e_slew, e_smt} = '0;
            e_pull = {N{2'h1}};
            e_drv = {N{2'h1}};
        end else if (clk_en_i) begin
            for (int g = 0; g < N; g++) begin
                e_out[g] = func_out_i[g*4+ctrl_m[g][1:0]];
                case (ctrl_m[g][4:3])
                    2'h1: e_oe[g] = func_oe_i[g*4+ctrl_m[g][1:0]];
                    2'h2: e_oe[g] = fabric_oe_i[g];
                    default: e_oe[g] = ~ctrl_m[g][5];
                endcase
                e_rx[g] = pad_in_i[g] & ctrl_m[g][11];
                e_pull[g*2+:2] = ctrl_m[g][7:6];
                e_drv[g*2+:2] = ctrl_m[g][9:8];
                e_slew[g] = ctrl_m[g][10];
                e_smt[g] = ctrl_m[g][12];
            end
            e_lock = lock_m;
            p = pad_of(reg_addr_i);
            if (reg_rd_i)
                e_rd = (reg_addr_i == L) ? {31'h0, lock_m} : (p >= 0) ? {19'h0, ctrl_m[p]} : '0;
            if (reg_wr_i && reg_addr_i == L)
                lock_m = (reg_wdata_i !== `PADMUX_LOCK_KEY);
            else if (reg_wr_i && p >= 0 && !(p == `PADMUX_PROTECTED_PAD && lock_m))
                ctrl_m[p] = reg_wdata_i[12:0];
        end
    end

    task automatic chk(string nm, logic [91:0] e, logic [91:0] s);
        n_compared++;
        if (e !== s) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    always @(negedge ref_clk_i) if (armed) begin
        chk("pad_out", e_out, pad_out_o);
        chk("pad_oe", e_oe, pad_oe_o);
        chk("pad_rx", e_rx, pad_rx_o);
        chk("pad_pull", e_pull, pad_pull_o);
        chk("pad_drive", e_drv, pad_drive_o);
        chk("pad_slew", e_slew, pad_slew_fast_o);
        chk("pad_schmitt", e_smt, pad_schmitt_enable_o);
        chk("rdata", e_rd, reg_rdata_o);
        chk("lock", e_lock, lock_active_o);
    end

    task automatic bus(logic w, logic r, logic [31:0] a, logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= w;
        reg_rd_i <= r;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (int g = 0; g <= N; g++) bus(0, 1, B + 4 * g, 0);
        bus(0, 1, L, 0);
        for (int k = 0; k < 4; k++) begin
            if (k == 2)
                bus(1, 1, L, `PADMUX_LOCK_KEY);
            for (int g = 0; g < N; g++) bus(1, 1'($random(seed)), B + 4 * g, $random(seed));
        end
        bus(1, 0, L, `PADMUX_LOCK_KEY ^ 32'h8);
        bus(1, 1, B + 4 * `PADMUX_PROTECTED_PAD, 32'h1fff);
        bus(1, 1, B + 1, 32'h1fff);
        bus(1, 1, B + 4 * N, 32'h1fff);
        bus(0, 1, B + 4 * `PADMUX_PROTECTED_PAD, 0);
        // Writes while frozen must be lost, and reset must still land with the enable low.
        clk_en_i <= 1'b0;
        for (int g = 0; g < 3; g++) bus(1, 1, B + 4 * g, $random(seed));
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        clk_en_i <= 1'b1;
        for (int g = 0; g < 3; g++) bus(0, 1, B + 4 * g, 0);
        bus(0, 1, L, 0);
        finish_test;
    end

    initial begin
        #300000;
        bad_count++;
        finish_test;
    end
endmodule

//--- testbench/padmux_pad_world.sv
`timescale 1ns/1ns

// Stands in for the peripherals, the fabric and the board behind every pad.
// A pad that nobody drives follows its pull; with no pull it toggles, so a stale value is never mistaken for a match.
module padmux_pad_world #(
    parameter int NUM_PADS = 46
) (
    input  wire logic                  ref_clk_i,
    input  wire logic [NUM_PADS-1:0]   pad_out_i,
    input  wire logic [NUM_PADS-1:0]   pad_oe_i,
    input  wire logic [NUM_PADS*2-1:0] pad_pull_i,
    output logic      [NUM_PADS*4-1:0] func_out_o,
    output logic      [NUM_PADS*4-1:0] func_oe_o,
    output logic      [NUM_PADS-1:0]   fabric_oe_o,
    output logic      [NUM_PADS-1:0]   pad_in_o
);
    integer              seed = 32'h319c;
    logic [NUM_PADS-1:0] ext_drive = '0;

    initial begin
        func_out_o = '0;
        func_oe_o = '0;
        fabric_oe_o = '0;
        pad_in_o = '0;
    end

    always @(posedge ref_clk_i) begin
        for (int g = 0; g < NUM_PADS; g++) begin
            func_out_o[g*4+:4] <= 4'($random(seed));
            func_oe_o[g*4+:4] <= 4'($random(seed));
            fabric_oe_o[g] <= 1'($random(seed));
            ext_drive[g] <= 1'($random(seed));
            if (pad_oe_i[g])
                pad_in_o[g] <= pad_out_i[g];
            else if (ext_drive[g])
                pad_in_o[g] <= 1'($random(seed));
            else
                case (pad_pull_i[g*2+:2])
                    2'h1: pad_in_o[g] <= 1'b1;
                    2'h2: pad_in_o[g] <= 1'b0;
                    2'h3: pad_in_o[g] <= pad_in_o[g];
                    default: pad_in_o[g] <= ~pad_in_o[g];
                endcase
        end
    end
endmodule

//--- verilog/padmux_pad_slice.sv
`timescale 1ns/1ns
`include "padmux_params.svh"

// One pad: output function mux, enable source mux and receive gate, all registered.
module padmux_pad_slice
    import padmux_pkg::*;
(
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    input  wire logic [12:0] ctrl_i,
    input  wire logic [3:0]  func_out_i,
    input  wire logic [3:0]  func_oe_i,
    input  wire logic        fabric_oe_i,
    input  wire logic        pad_in_i,
    output logic             pad_out_o,
    output logic             pad_oe_o,
    output logic             pad_rx_o
);
    logic [1:0] fsel;
    logic [1:0] osrc;

    assign fsel = ctrl_i[`PADMUX_FSEL_LSB +: 2];
    assign osrc = ctrl_i[`PADMUX_OSRC_LSB +: 2];

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pad_out_o <= 1'h0;
        end else if (clk_en_i) begin
            pad_out_o <= func_out_i[fsel]; // R2
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pad_oe_o <= 1'h0;
        end else if (clk_en_i) begin
            unique case (padmux_oe_src_t'(osrc))
                PADMUX_OE_PERIPHERAL: pad_oe_o <= func_oe_i[fsel]; // R7
                PADMUX_OE_FABRIC:     pad_oe_o <= fabric_oe_i; // R8
                PADMUX_OE_REGISTER,
                PADMUX_OE_UNDEFINED:  pad_oe_o <= ~ctrl_i[`PADMUX_OEN_BIT]; // R6 R9 R22
            endcase
        end
    end

    // Input sampling never looks at the function select, so input-only pads work with any value there.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            pad_rx_o <= 1'h0;
        end else if (clk_en_i) begin
            pad_rx_o <= pad_in_i & ctrl_i[`PADMUX_REN_BIT]; // R13 R20
        end
    end

    reg_oe_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
        clk_en_i && (ctrl_i[4:3] == 2'h0 || ctrl_i[4:3] == 2'h3) |=> pad_oe_o == !$past(ctrl_i[5]))
        else $error("register enable not followed");
    fab_oe_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
        clk_en_i && ctrl_i[4:3] == 2'h2 |=> pad_oe_o == $past(fabric_oe_i))
        else $error("fabric enable not followed");
    rx_gate_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
        clk_en_i && !ctrl_i[11] |=> !pad_rx_o)
        else $error("receive gate leaks");
endmodule

//--- verilog/padmux_params.svh
`ifndef PADMUX_PARAMS_SVH
`define PADMUX_PARAMS_SVH

`define PADMUX_NUM_PADS         46
`define PADMUX_PAD0_ADDR        32'h4000_4c00
`define PADMUX_PAD_STRIDE       32'h0000_0004
`define PADMUX_LOCK_ADDR        32'h4000_5310
`define PADMUX_LOCK_KEY         32'h1acc_e551
`define PADMUX_PROTECTED_PAD    43
`define PADMUX_PROT_MSB         12

`define PADMUX_FSEL_LSB         0
`define PADMUX_OSRC_LSB         3
`define PADMUX_OEN_BIT          5
`define PADMUX_PULL_LSB         6
`define PADMUX_DRIVE_LSB        8
`define PADMUX_SLEW_BIT         10
`define PADMUX_REN_BIT          11
`define PADMUX_SMT_BIT          12
`define PADMUX_CTRL_WIDTH       13

`define PADMUX_CTRL_RESET       13'h0160
`define PADMUX_LOCK_RESET       1'h1

`endif

//--- verilog/padmux_pkg.sv
package padmux_pkg;

    typedef enum logic [1:0] {
        PADMUX_OE_REGISTER,
        PADMUX_OE_PERIPHERAL,
        PADMUX_OE_FABRIC,
        PADMUX_OE_UNDEFINED
    } padmux_oe_src_t;

    typedef enum logic [1:0] {
        PADMUX_PULL_NONE,
        PADMUX_PULL_UP,
        PADMUX_PULL_DOWN,
        PADMUX_PULL_KEEPER
    } padmux_pull_t;

endpackage

//--- verilog/padmux_top.sv
`timescale 1ns/1ns
`include "padmux_params.svh"

// Behaviour
// R1 - 46 pads, each independently configured
// R2 - Bits 1:0 pick one of four outputs
// R3 - Pad 0: i2c0 clock, fabric io 0
// R4 - Pad 1: i2c0 data, fabric io 1
// R5 - Pad 2: fabric, sensor select, debug, battery
// R6 - Enable source 0 uses register enable bit
// R7 - Enable source 1 uses peripheral enable
// R8 - Enable source 2 uses fabric enable
// R9 - Bit 5 active low, resets to one
// R10 - Bits 7:6 pull state, reset pull-up
// R11 - Bits 9:8 drive strength, reset 4 mA
// R12 - Bit 10 fast slew, reset slow
// R13 - Bit 11 gates pad toward inputs
// R14 - Bit 12 Schmitt enable, reset off
// R15 - Power cycle or chip reset restores defaults
// R16 - Processor, host, debugger access; no fabric
// R17 - Key unlocks; other value relocks
// R18 - Lock bit resets to one
// R19 - Pad 43 bits 12:0 lock protected
// R20 - Input sampling ignores function select
// R21 - Pad registers at four-byte stride
// R22 - Enable source 3 acts as 0
module padmux_top
    import padmux_pkg::*;
#(
    parameter int NUM_PADS = `PADMUX_NUM_PADS
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  clk_en_i,
    input  wire logic                  reg_wr_i,
    input  wire logic                  reg_rd_i,
    input  wire logic [31:0]           reg_addr_i,
    input  wire logic [31:0]           reg_wdata_i,
    output logic      [31:0]           reg_rdata_o,
    input  wire logic [NUM_PADS*4-1:0] func_out_i,
    input  wire logic [NUM_PADS*4-1:0] func_oe_i,
    input  wire logic [NUM_PADS-1:0]   fabric_oe_i,
    input  wire logic [NUM_PADS-1:0]   pad_in_i,
    output logic      [NUM_PADS-1:0]   pad_out_o,
    output logic      [NUM_PADS-1:0]   pad_oe_o,
    output logic      [NUM_PADS-1:0]   pad_rx_o,
    output logic      [NUM_PADS*2-1:0] pad_pull_o,
    output logic      [NUM_PADS*2-1:0] pad_drive_o,
    output logic      [NUM_PADS-1:0]   pad_slew_fast_o,
    output logic      [NUM_PADS-1:0]   pad_schmitt_enable_o,
    output logic                       lock_active_o
);
    // The register port is shared by processor, host bridge and debugger; fabric has no path here. R16
    logic [12:0] ctrl [NUM_PADS];
    logic        lock_en;
    logic [31:0] pad_offset;
    logic [31:0] pad_index;
    logic        pad_hit;
    logic        lock_hit;

    assign pad_offset = reg_addr_i - `PADMUX_PAD0_ADDR;
    assign pad_index  = {2'h0, pad_offset[31:2]};
    assign pad_hit    = reg_addr_i >= `PADMUX_PAD0_ADDR && pad_offset[1:0] == 2'h0
                        && pad_index < 32'(NUM_PADS); // R21
    assign lock_hit   = reg_addr_i == `PADMUX_LOCK_ADDR;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            lock_en <= `PADMUX_LOCK_RESET; // R15 R18
        end else if (clk_en_i && reg_wr_i && lock_hit) begin
            lock_en <= reg_wdata_i != `PADMUX_LOCK_KEY; // R17
        end
    end

    // Each pad owns its register, so a write touches only the addressed one. R1
    genvar g;
    generate
        for (g = 0; g < NUM_PADS; g++) begin : gen_pad
            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    ctrl[g] <= `PADMUX_CTRL_RESET; // R9 R10 R11 R12 R14 R15
                end else if (clk_en_i && reg_wr_i && pad_hit && pad_index == 32'(g)
                             && !(g == `PADMUX_PROTECTED_PAD && lock_en)) begin // R19
                    ctrl[g] <= reg_wdata_i[12:0];
                end
            end

            // Function inputs per pad: slot 0..3 follows the select encoding, e.g. pad 0 i2c0 clock then
            // fabric io, pad 2 fabric, sensor select, debug monitor, battery monitor. R3 R4 R5
            padmux_pad_slice u_slice (
                .ref_clk_i   (ref_clk_i),
                .reset_i     (reset_i),
                .clk_en_i    (clk_en_i),
                .ctrl_i      (ctrl[g]),
                .func_out_i  (func_out_i[g*4 +: 4]),
                .func_oe_i   (func_oe_i[g*4 +: 4]),
                .fabric_oe_i (fabric_oe_i[g]),
                .pad_in_i    (pad_in_i[g]),
                .pad_out_o   (pad_out_o[g]),
                .pad_oe_o    (pad_oe_o[g]),
                .pad_rx_o    (pad_rx_o[g])
            );

            always_ff @(posedge ref_clk_i) begin
                if (reset_i) begin
                    pad_pull_o[g*2 +: 2]    <= 2'h1;
                    pad_drive_o[g*2 +: 2]   <= 2'h1;
                    pad_slew_fast_o[g]      <= 1'h0;
                    pad_schmitt_enable_o[g] <= 1'h0;
                end else if (clk_en_i) begin
                    pad_pull_o[g*2 +: 2]    <= ctrl[g][`PADMUX_PULL_LSB +: 2]; // R10
                    pad_drive_o[g*2 +: 2]   <= ctrl[g][`PADMUX_DRIVE_LSB +: 2]; // R11
                    pad_slew_fast_o[g]      <= ctrl[g][`PADMUX_SLEW_BIT]; // R12
                    pad_schmitt_enable_o[g] <= ctrl[g][`PADMUX_SMT_BIT]; // R14
                end
            end
        end
    endgenerate

    // Lock state also goes out to protected registers living in other blocks.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            lock_active_o <= 1'h1;
        end else if (clk_en_i) begin
            lock_active_o <= lock_en; // R19
        end
    end

    // Read data is registered; unmapped addresses return zero.
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            reg_rdata_o <= 32'h0;
        end else if (clk_en_i && reg_rd_i) begin
            if (pad_hit) begin
                reg_rdata_o <= {19'h0, ctrl[pad_index[5:0]]};
            end else if (lock_hit) begin
                reg_rdata_o <= {31'h0, lock_en}; // R18
            end else begin
                reg_rdata_o <= 32'h0;
            end
        end
    end

    // Reset checks carry no enable term, because reset overrides the freeze.
    relock_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
        clk_en_i && reg_wr_i && lock_hit && reg_wdata_i != 32'h1acce551 |=> lock_en)
        else $error("lock not restored");

    unlock_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
        clk_en_i && reg_wr_i && lock_hit && reg_wdata_i == 32'h1acce551 |=> !lock_en)
        else $error("key did not unlock");

    key_only_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R17
        clk_en_i && reg_wr_i && !lock_hit |=> $stable(lock_en))
        else $error("lock moved without a lock write");

    freeze_lock_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R18
        !clk_en_i && !reset_i |=> $stable(lock_en) && $stable(lock_active_o))
        else $error("lock moved while frozen");

    lock_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R19
        clk_en_i |=> lock_active_o == $past(lock_en))
        else $error("lock output stale");

    read_lock_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R18
        clk_en_i && reg_rd_i && lock_hit |=> reg_rdata_o == {31'h0, $past(lock_en)})
        else $error("lock read wrong");

    protect_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R19
        lock_en && !(reg_wr_i && lock_hit) |=> $stable(ctrl[43]))
        else $error("locked pad register changed");

    unlock_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R19
        clk_en_i && !lock_en && reg_wr_i && reg_addr_i == 32'h4000_4cac |=> ctrl[43] == $past(reg_wdata_i[12:0]))
        else $error("unlocked protected write lost");

    pad_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
        clk_en_i && reg_wr_i && reg_addr_i == 32'h4000_4c04 |=> ctrl[1] == $past(reg_wdata_i[12:0]))
        else $error("pad write lost");

    stride_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
        clk_en_i && reg_wr_i && reg_addr_i == 32'h4000_4cb4 |=> ctrl[45] == $past(reg_wdata_i[12:0]))
        else $error("last pad write lost");

    other_pad_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R1
        clk_en_i && reg_wr_i && reg_addr_i != 32'h4000_4c00 |=> $stable(ctrl[0]))
        else $error("pad 0 changed by another write");

    misalign_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
        clk_en_i && reg_wr_i && reg_addr_i[1:0] != 2'h0 |=> $stable(ctrl[0]) && $stable(ctrl[1]))
        else $error("misaligned write landed");

    unmapped_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
        clk_en_i && reg_wr_i && reg_addr_i == 32'h4000_4cb8 |=> $stable(ctrl[45]))
        else $error("write past last pad landed");

    read_pad_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
        clk_en_i && reg_rd_i && reg_addr_i == 32'h4000_4c00 |=> reg_rdata_o == {19'h0, $past(ctrl[0])})
        else $error("pad 0 read wrong");

    read_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
        clk_en_i && reg_rd_i && reg_addr_i == 32'h4000_4cb4 |=> reg_rdata_o == {19'h0, $past(ctrl[45])})
        else $error("last pad read wrong");

    read_zero_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
        clk_en_i && reg_rd_i && !pad_hit && !lock_hit |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");

    rdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
        !reset_i && !(clk_en_i && reg_rd_i) |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");

    lock_reset_a: assert property (@(posedge ref_clk_i) // R15
        reset_i |=> lock_en && ctrl[0] == 13'h0160)
        else $error("reset values wrong");

    reset_out_a: assert property (@(posedge ref_clk_i) // R15
        reset_i |=> lock_active_o && reg_rdata_o == 32'h0 && pad_out_o == '0 && pad_oe_o == '0)
        else $error("bus or pad outputs not reset");

    reset_pads_a: assert property (@(posedge ref_clk_i) // R15
        reset_i |=> pad_rx_o == '0 && pad_slew_fast_o == '0 && pad_schmitt_enable_o == '0)
        else $error("pad settings not reset");

    reset_drive_a: assert property (@(posedge ref_clk_i) // R11
        reset_i |=> pad_pull_o == {NUM_PADS{2'h1}} && pad_drive_o == {NUM_PADS{2'h1}})
        else $error("pull or drive not reset");

    reset_ctrl_a: assert property (@(posedge ref_clk_i) // R9
        reset_i |=> ctrl[43] == `PADMUX_CTRL_RESET && ctrl[45] == `PADMUX_CTRL_RESET)
        else $error("pad registers not reset");

    // Pad outputs follow the stored register one enabled edge later.
    out_pad0_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
        clk_en_i && !reset_i |=> pad_out_o[0] == $past(func_out_i[ctrl[0][1:0]]))
        else $error("pad 0 output select wrong");

    out_pad1_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R4
        clk_en_i && !reset_i |=> pad_out_o[1] == $past(func_out_i[4 + ctrl[1][1:0]]))
        else $error("pad 1 output select wrong");

    out_pad2_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
        clk_en_i && !reset_i |=> pad_out_o[2] == $past(func_out_i[8 + ctrl[2][1:0]]))
        else $error("pad 2 output select wrong");

    out_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
        clk_en_i && !reset_i |=> pad_out_o[45] == $past(func_out_i[180 + ctrl[45][1:0]]))
        else $error("last pad output select wrong");

    periph_oe_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
        clk_en_i && !reset_i && ctrl[0][4:3] == 2'h1 |=> pad_oe_o[0] == $past(func_oe_i[ctrl[0][1:0]]))
        else $error("peripheral enable not followed");

    periph_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
        clk_en_i && !reset_i && ctrl[45][4:3] == 2'h1 |=> pad_oe_o[45] == $past(func_oe_i[180 + ctrl[45][1:0]]))
        else $error("last pad peripheral enable wrong");

    fabric_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
        clk_en_i && !reset_i && ctrl[45][4:3] == 2'h2 |=> pad_oe_o[45] == $past(fabric_oe_i[45]))
        else $error("last pad fabric enable wrong");

    undef_src_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R22
        clk_en_i && !reset_i && ctrl[1][4:3] == 2'h3 |=> pad_oe_o[1] == !$past(ctrl[1][5]))
        else $error("source 3 not treated as register");

    oe_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R9
        clk_en_i && !reset_i && ctrl[0][4:3] == 2'h0 && ctrl[0][5] |=> !pad_oe_o[0])
        else $error("driver on with enable bit high");

    rx_pass_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
        clk_en_i && !reset_i && ctrl[0][11] |=> pad_rx_o[0] == $past(pad_in_i[0]))
        else $error("receive path blocked");

    rx_block_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R13
        clk_en_i && !reset_i && !ctrl[45][11] |=> !pad_rx_o[45])
        else $error("last pad receive gate leaks");

    pull_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
        clk_en_i && !reset_i |=> pad_pull_o[1:0] == $past(ctrl[0][7:6]))
        else $error("pull output mismatch");

    pull_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
        clk_en_i && !reset_i |=> pad_pull_o[91:90] == $past(ctrl[45][7:6]))
        else $error("last pad pull mismatch");

    drive_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
        clk_en_i && !reset_i |=> pad_drive_o[1:0] == $past(ctrl[0][9:8]))
        else $error("drive output mismatch");

    drive_last_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R11
        clk_en_i && !reset_i |=> pad_drive_o[91:90] == $past(ctrl[45][9:8]))
        else $error("last pad drive mismatch");

    slew_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
        clk_en_i && !reset_i |=> pad_slew_fast_o[0] == $past(ctrl[0][10]))
        else $error("slew output mismatch");

    schmitt_out_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R14
        clk_en_i && !reset_i |=> pad_schmitt_enable_o[0] == $past(ctrl[0][12]))
        else $error("schmitt output mismatch");

    freeze_pads_a: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
        !clk_en_i && !reset_i |=> $stable(pad_out_o) && $stable(pad_oe_o) && $stable(ctrl[0]))
        else $error("pad state moved while frozen");
endmodule
